// [src/fpc_flash_ctrl.sv]
`timescale 1ns/100ps
`include "fpc_defs.svh"
module fpc_flash_ctrl
  import fpc_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic [3:0]  io_i,
  output logic      [3:0]  io_o,
  output logic      [3:0]  io_oe_o,
  input  wire logic        qpi_mode_i,
  input  wire logic        wip_i,
  input  wire logic        wel_i,
  input  wire logic        prot_err_i,
  input  wire logic        prog_err_i,
  input  wire logic        erase_err_i,
  input  wire logic        dedicated_rst_i,
  input  wire fpc_addr_t   rd_addr_i,
  output fpc_addr_t        rd_addr_next_o,
  output logic             deep_sleep_o,
  output logic             ready_o,
  output logic      [7:0]  read_params_o,
  output logic      [3:0]  dummy_cycles_o,
  output logic      [2:0]  drive_strength_o,
  output logic      [7:0]  ext_params_o,
  output logic             rst_pin_is_reset_o,
  output logic             wel_clr_o
);
  localparam int SLEEP_MAX = `FPC_SLEEP_WAIT + 1;

  // ---------------- link side, runs on sclk_i ----------------
  logic [5:0]   ecnt_reg;
  logic         ovf_reg;
  logic         tgl_reg;
  logic [5:0]   len_reg;
  logic         lovf_reg;
  logic [7:0]   op_s_reg;
  logic [7:0]   dat_s_reg;
  logic [7:0]   op_q_reg;
  logic [7:0]   dat_q_reg;
  logic         drv_reg;
  logic [3:0]   out_reg;
  logic [17:0]  l_sync;
  logic         l_qpi;
  logic         l_run;
  logic [7:0]   l_rp;
  logic [7:0]   l_ex;
  logic [7:0]   l_op;
  logic         l_rd_cmd;
  logic         l_rd_phase;
  logic [7:0]   l_byte;

  // ---------------- core side ----------------
  fpc_pm_t      st_reg;
  logic [`FPC_TMR_W-1:0] tmr_reg;
  logic [7:0]   rp_nv_reg;
  logic [7:0]   rp_v_reg;
  logic [2:0]   ods_nv_reg;
  logic [2:0]   ods_v_reg;
  logic [2:0]   err_reg;
  logic [7:0]   ext_reg;
  logic         run_reg;
  logic         cs_d_reg;
  logic         seen_reg;
  logic         rstsel_reg;
  logic         wel_clr_reg;
  fpc_addr_t    addr_next_reg;
  logic [2:0]   c_sync;
  logic         cs_s;
  logic         tgl_s;
  logic         ded_s;
  logic         exec;
  logic [7:0]   op;
  logic [7:0]   dat;
  logic         op_done;
  logic         wr_ok;
  logic         is_run;
  logic         go_sleep;
  logic         go_wake;
  logic         wr_rp_nv;
  logic         wr_rp_v;
  logic         wr_ex_nv;
  logic         wr_ex_v;
  logic         clr_err;
  fpc_wrap_if   wif ();

  // edge counter cleared by chip select high or reset; wraps so reads repeat
  always_ff @(posedge sclk_i or posedge cs_n_i or negedge rst_n_i) begin
    if (cs_n_i || !rst_n_i) begin
      ecnt_reg <= 6'h00;
      ovf_reg  <= 1'b0;
    end else begin
      ecnt_reg <= ecnt_reg + 6'h01;
      if (ecnt_reg == 6'h3F) begin
        ovf_reg <= 1'b1;
      end
    end
  end

  // frame capture; held after cs rises since sclk then stands still
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tgl_reg   <= 1'b0;
      len_reg   <= 6'h00;
      lovf_reg  <= 1'b0;
      op_s_reg  <= 8'h00;
      dat_s_reg <= 8'h00;
      op_q_reg  <= 8'h00;
      dat_q_reg <= 8'h00;
    end else begin
      if (ecnt_reg == 6'h00 && !ovf_reg) begin
        tgl_reg <= ~tgl_reg; // new frame event for the core side
      end
      len_reg  <= ecnt_reg + 6'h01;
      lovf_reg <= ovf_reg | (ecnt_reg == 6'h3F);
      // both views shift in parallel; the core picks one by its mode
      if (!ovf_reg && ecnt_reg < 6'h08) begin
        op_s_reg <= {op_s_reg[6:0], io_i[0]};
      end
      if (!ovf_reg && ecnt_reg[5:3] == 3'h1) begin
        dat_s_reg <= {dat_s_reg[6:0], io_i[0]};
      end
      if (!ovf_reg && ecnt_reg < 6'h02) begin
        op_q_reg <= {op_q_reg[3:0], io_i};
      end
      if (!ovf_reg && ecnt_reg[5:1] == 5'h01) begin
        dat_q_reg <= {dat_q_reg[3:0], io_i};
      end
    end
  end

  // core levels into the link domain, flushed by the first opcode edges
  fpc_sync #(.W(18)) u_to_link (
    .clk_i   (sclk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({qpi_mode_i, run_reg, rp_v_reg, ext_reg}),
    .q_o     (l_sync)
  );
  assign l_qpi = l_sync[17];
  assign l_run = l_sync[16];
  assign l_rp  = l_sync[15:8];
  assign l_ex  = l_sync[7:0];

  // read decode; asleep or recovering the link stays silent
  always_comb begin
    l_op       = l_qpi ? op_q_reg : op_s_reg;
    l_rd_phase = ovf_reg || (l_qpi ? (ecnt_reg >= 6'h02) : (ecnt_reg >= 6'h08));
    l_rd_cmd   = l_run && (l_op == `FPC_OP_RD_RP || l_op == `FPC_OP_RD_EX);
    l_byte     = (l_op == `FPC_OP_RD_RP) ? l_rp : l_ex;
  end

  // data out on the falling edge, msb first, repeating every byte
  always_ff @(negedge sclk_i or posedge cs_n_i or negedge rst_n_i) begin
    if (cs_n_i || !rst_n_i) begin
      drv_reg <= 1'b0;
      out_reg <= 4'h0;
    end else begin
      drv_reg <= l_rd_cmd && l_rd_phase;
      if (l_qpi) begin
        out_reg <= ecnt_reg[0] ? l_byte[3:0] : l_byte[7:4];
      end else begin
        out_reg <= {2'h0, l_byte[~ecnt_reg[2:0]], 1'b0};
      end
    end
  end

  assign io_o    = out_reg;
  assign io_oe_o = drv_reg ? (l_qpi ? 4'hF : 4'h2) : 4'h0;

  // ---------------- core side ----------------
  fpc_sync #(.W(3)) u_to_core (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({cs_n_i, tgl_reg, dedicated_rst_i}),
    .q_o     (c_sync)
  );
  assign cs_s  = c_sync[2];
  assign tgl_s = c_sync[1];
  assign ded_s = c_sync[0];

  // frame end: cs rose and the frame saw at least one edge
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_d_reg <= 1'b1;
      seen_reg <= 1'b0;
    end else begin
      cs_d_reg <= cs_s;
      if (cs_s && !cs_d_reg) begin
        seen_reg <= tgl_s;
      end
    end
  end

  // frame fields are stable here; synchronised cs qualifies them
  always_comb begin
    exec    = cs_s && !cs_d_reg && (tgl_s != seen_reg);
    op      = qpi_mode_i ? op_q_reg : op_s_reg;
    dat     = qpi_mode_i ? dat_q_reg : dat_s_reg;
    op_done = lovf_reg || (qpi_mode_i ? (len_reg >= 6'h02) : (len_reg >= 6'h08));
    wr_ok   = qpi_mode_i ? (!len_reg[0] && (lovf_reg || len_reg >= 6'h04))
                         : (len_reg[2:0] == 3'h0 && (lovf_reg || len_reg >= 6'h10));
    is_run  = (st_reg == ST_RUN);
    go_sleep = exec && is_run && op_done && op == `FPC_OP_SLEEP;
    go_wake  = exec && st_reg == ST_SLEEP && op_done && op == `FPC_OP_WAKE && !wip_i;
    wr_rp_nv = exec && is_run && wr_ok && op == `FPC_OP_RP_NV && wel_i;
    wr_rp_v  = exec && is_run && wr_ok &&
               ((op == `FPC_OP_RP_V_WEL && wel_i) || op == `FPC_OP_RP_V);
    wr_ex_nv = exec && is_run && wr_ok && op == `FPC_OP_EX_NV && wel_i;
    wr_ex_v  = exec && is_run && wr_ok && op == `FPC_OP_EX_V;
    clr_err  = exec && is_run && op_done && op == `FPC_OP_CLR_ERR;
  end

  // power state with entry and recovery timers
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg  <= ST_RUN;
      tmr_reg <= '0;
    end else begin
      case (st_reg)
        ST_RUN: begin
          if (go_sleep) begin
            st_reg  <= ST_ENTER;
            tmr_reg <= `FPC_TMR_W'(`FPC_SLEEP_WAIT);
          end
        end
        ST_ENTER: begin
          if (tmr_reg == '0) begin
            st_reg <= ST_SLEEP;
          end else begin
            tmr_reg <= tmr_reg - `FPC_TMR_W'(1);
          end
        end
        ST_SLEEP: begin
          if (go_wake) begin
            st_reg  <= ST_WAKE;
            tmr_reg <= `FPC_TMR_W'(`FPC_WAKE_CYC);
          end
        end
        ST_WAKE: begin
          if (tmr_reg == '0) begin
            st_reg <= ST_RUN;
          end else begin
            tmr_reg <= tmr_reg - `FPC_TMR_W'(1);
          end
        end
        default: st_reg <= ST_RUN;
      endcase
    end
  end

  // read parameters; sleep entry drops volatile edits back to persistent
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rp_nv_reg <= `FPC_RP_RESET;
      rp_v_reg  <= `FPC_RP_RESET;
    end else begin
      if (wr_rp_nv) begin
        rp_nv_reg <= dat;
        rp_v_reg  <= dat;
      end else if (wr_rp_v) begin
        rp_v_reg <= dat;
      end else if (st_reg == ST_ENTER && tmr_reg == '0) begin
        rp_v_reg <= rp_nv_reg;
      end
    end
  end

  // drive strength copies and sticky error flags; a set beats a clear
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ods_nv_reg <= `FPC_ODS_RESET;
      ods_v_reg  <= `FPC_ODS_RESET;
      err_reg    <= 3'h0;
    end else begin
      if (wr_ex_nv) begin
        ods_nv_reg <= dat[`FPC_EX_ODS_LSB +: 3];
        ods_v_reg  <= dat[`FPC_EX_ODS_LSB +: 3];
      end else if (wr_ex_v) begin
        ods_v_reg <= dat[`FPC_EX_ODS_LSB +: 3];
      end
      err_reg <= (clr_err ? 3'h0 : err_reg) | {erase_err_i, prog_err_i, prot_err_i};
    end
  end

  // volatile extended image with live write-in-progress
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_reg <= 8'h00;
      run_reg <= 1'b1;
    end else begin
      ext_reg <= {ods_v_reg, 1'b0, err_reg, wip_i};
      run_reg <= is_run;
    end
  end

  // pin function, latch clear pulse and next read address
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rstsel_reg    <= 1'b0;
      wel_clr_reg   <= 1'b0;
      addr_next_reg <= '0;
    end else begin
      rstsel_reg    <= ded_s | rp_v_reg[`FPC_RP_HOLDRST];
      wel_clr_reg   <= wr_rp_nv || wr_ex_nv || (wr_rp_v && op == `FPC_OP_RP_V_WEL);
      addr_next_reg <= wif.next;
    end
  end

  assign wif.addr    = rd_addr_i;
  assign wif.wrap_en = rp_v_reg[`FPC_RP_WRAP_BIT];
  assign wif.wlen    = rp_v_reg[1:0];

  fpc_wrap_gen u_wrap (
    .w (wif.gen)
  );

  assign rd_addr_next_o     = addr_next_reg;
  assign deep_sleep_o       = (st_reg == ST_SLEEP);
  assign ready_o            = is_run;
  assign read_params_o      = rp_v_reg;
  assign dummy_cycles_o     = rp_v_reg[`FPC_RP_DUMMY_LSB +: 4];
  assign drive_strength_o   = ods_v_reg;
  assign ext_params_o       = ext_reg;
  assign rst_pin_is_reset_o = rstsel_reg;
  assign wel_clr_o          = wel_clr_reg;

  // checks on the core domain
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_enter;
    $rose(st_reg == ST_ENTER);
  endsequence
  sequence s_wake;
    $rose(st_reg == ST_WAKE);
  endsequence

  sleep_entry_a: assert property (
    s_enter |-> ##[1:SLEEP_MAX] (st_reg == ST_SLEEP))
    else $error("sleep not reached in time");
  short_frame_a: assert property (
    (exec && is_run && !op_done) |=> (st_reg == ST_RUN))
    else $error("partial opcode changed power state");
  sleep_quiet_a: assert property (
    (st_reg == ST_SLEEP && exec) |=> ($stable(rp_v_reg) && $stable(rp_nv_reg) && !wel_clr_o))
    else $error("command acted while asleep");
  wake_hold_a: assert property (
    s_wake |-> (st_reg == ST_WAKE && $stable(rp_v_reg))[*8])
    else $error("recovery cut short");
  wip_release_a: assert property (
    (exec && st_reg == ST_SLEEP && wip_i) |=> (st_reg == ST_SLEEP))
    else $error("release taken while busy");
  nv_gate_a: assert property (
    $changed(rp_nv_reg) |-> $past(wel_i))
    else $error("persistent write without latch");
  nv_mirror_a: assert property (
    wr_rp_nv |=> (rp_v_reg == rp_nv_reg && rp_nv_reg == $past(dat)))
    else $error("volatile copy not loaded");
  ext_mirror_a: assert property (
    wr_ex_nv |=> (ods_v_reg == ods_nv_reg) ##1 (ext_reg[7:5] == ods_nv_reg))
    else $error("extended copy not loaded");
  err_sticky_a: assert property (
    ($fell(err_reg[0]) || $fell(err_reg[1]) || $fell(err_reg[2])) |-> $past(clr_err))
    else $error("error flag dropped without clear");
  wrap_page_a: assert property (
    (rp_v_reg[2] && rd_addr_i[5:0] == 6'h3F) |=> (addr_next_reg[23:6] == $past(rd_addr_i[23:6])))
    else $error("wrap left its boundary");
endmodule

// [src/fpc_defs.svh]
`ifndef FPC_DEFS_SVH
`define FPC_DEFS_SVH
// How it works
// - sleep is entered only if chip select rises after the whole opcode
// - sleep is reached within the entry delay after chip select rises
// - while asleep only the release opcode is recognised, all else ignored
// - after release nothing is accepted until the wake recovery time ends
// - release is ignored while a write is in progress
// - read params: burst bits 2:0, dummy cycles 6:3, hold/reset select bit 7
// - persistent read-param write needs the write enable latch set
// - volatile write 63h needs the latch, C0h does not and leaves it unchanged
// - persistent read-param write also loads the volatile copy
// - burst values 0-3 read linearly, 4-7 wrap at 8/16/32/64 bytes
// - wrapping reads return to the aligned boundary start within a page
// - wrap stays on until cleared by a volatile or persistent write, by reset, or by sleep entry when the persistent copy has it off
// - wrap applies to every read once enabled
// - a wrapping read cycles until chip select rises
// - extended register holds a 3-bit drive strength, default half drive
// - 85h writes persistent extended copy and volatile copy, 83h volatile
// - read-param read returns the volatile copy only
// - extended read returns the volatile copy and works during writes
// - error flags stay set until the clear opcode runs
// - sleep entry works in single-line and four-line mode
// - a dedicated reset pin ignores the hold/reset select bit
// - four-line mode moves each byte as two nibbles, high nibble first
`define FPC_OP_SLEEP      8'hB9
`define FPC_OP_WAKE       8'hAB
`define FPC_OP_RP_NV      8'h65
`define FPC_OP_RP_V_WEL   8'h63
`define FPC_OP_RP_V       8'hC0
`define FPC_OP_EX_NV      8'h85
`define FPC_OP_EX_V       8'h83
`define FPC_OP_RD_RP      8'h61
`define FPC_OP_RD_EX      8'h81
`define FPC_OP_CLR_ERR    8'h82
`define FPC_RP_WRAP_BIT   2
`define FPC_RP_DUMMY_LSB  3
`define FPC_RP_HOLDRST    7
`define FPC_EX_WIP        0
`define FPC_EX_ERR_LSB    1
`define FPC_EX_ODS_LSB    5
`define FPC_RP_RESET      8'h00
`define FPC_ODS_RESET     3'h5
`define FPC_CLK_MHZ       100
`define FPC_T_SLEEP_NS    3000
`define FPC_T_WAKE_NS     5000
`define FPC_SLEEP_CYC     ((`FPC_T_SLEEP_NS * `FPC_CLK_MHZ) / 1000)
`define FPC_WAKE_CYC      ((`FPC_T_WAKE_NS * `FPC_CLK_MHZ + 999) / 1000)
`define FPC_CS_LAT        4
`define FPC_SLEEP_WAIT    (`FPC_SLEEP_CYC - `FPC_CS_LAT)
`define FPC_TMR_W         10
`endif

// [src/fpc_pkg.sv]
package fpc_pkg;
  typedef enum logic [1:0] {ST_RUN, ST_ENTER, ST_SLEEP, ST_WAKE} fpc_pm_t;
  typedef logic [23:0] fpc_addr_t;
endpackage

// [src/fpc_wrap_if.sv]
`timescale 1ns/100ps
interface fpc_wrap_if;
  import fpc_pkg::*;
  fpc_addr_t  addr;
  fpc_addr_t  next;
  logic       wrap_en;
  logic [1:0] wlen;
  modport core (output addr, output wrap_en, output wlen, input next);
  modport gen (input addr, input wrap_en, input wlen, output next);
endinterface

// [src/fpc_sync.sv]
`timescale 1ns/100ps
module fpc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  // two stages; meta_reg feeds only q_reg
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      q_reg    <= '0;
    end else begin
      meta_reg <= d_i;
      q_reg    <= meta_reg;
    end
  end

  assign q_o = q_reg;
endmodule

// [src/fpc_wrap_gen.sv]
`timescale 1ns/100ps
module fpc_wrap_gen (
  fpc_wrap_if.gen w
);
  logic [7:0] mask;
  logic [7:0] inc;

  // boundary mask per burst length, next address stays inside it
  always_comb begin
    inc = w.addr[7:0] + 8'h01;
    case (w.wlen)
      2'h0:    mask = 8'h07;
      2'h1:    mask = 8'h0F;
      2'h2:    mask = 8'h1F;
      default: mask = 8'h3F;
    endcase
    if (w.wrap_en) begin
      w.next = {w.addr[23:8], (w.addr[7:0] & ~mask) | (inc & mask)};
    end else begin
      w.next = w.addr + 24'h000001;
    end
  end
endmodule

// [tb/fpc_host_model.sv]
`timescale 1ns/100ps
// host end of the link: clock only moves inside a frame, idles low
module fpc_host_model (
  output logic            sclk_o,
  output logic            cs_n_o,
  output logic      [3:0] io_o,
  input  wire logic [3:0] pin_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    io_o   = 4'h0;
  end

  // one frame: opcode, write and read units (bits, or nibbles in four-line)
  task automatic frame(input logic q, input logic [7:0] op, input int nop,
                       input logic [7:0] dat, input int nwr, input int nrd,
                       output logic [15:0] rd);
    logic [15:0] sh;
    logic [3:0]  nxt;
    sh = {op, dat};
    rd = 16'h0000;
    #3 cs_n_o = 1'b0;
    for (int i = 0; i < nop + nwr + nrd; i++) begin
      // idle lines toggle so a stale level never passes for data
      nxt = ~io_o;
      if (i < nop + nwr) begin
        if (q) begin
          nxt = sh[15:12];
        end else begin
          nxt[0] = sh[15];
        end
        sh = q ? sh << 4 : sh << 1;
      end
      io_o = nxt;
      #6 sclk_o = 1'b1;
      if (i >= nop + nwr) rd = q ? {rd[11:0], pin_i} : {rd[14:0], pin_i[1]};
      #6 sclk_o = 1'b0;
    end
    #6 cs_n_o = 1'b1;
    io_o = ~io_o;
  endtask
endmodule

// [tb/tb.sv]
`timescale 1ns/100ps
`include "fpc_defs.svh"
`define TB_CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb;
  import fpc_pkg::*;
  logic        core_clk_i, rst_n_i, qpi_mode_i, wip_i, wel_i, dedicated_rst_i;
  logic        prot_err_i, prog_err_i, erase_err_i, sclk, cs_n;
  logic        deep_sleep_o, ready_o, rst_pin_is_reset_o, wel_clr_o;
  logic [3:0]  host_io, pins, io_o, io_oe_o, dummy_cycles_o;
  logic [7:0]  read_params_o, ext_params_o;
  logic [2:0]  drive_strength_o;
  logic [15:0] rd;
  fpc_addr_t   rd_addr_i, rd_addr_next_o, exp_a;
  int          n_errors = 0;
  int          tests_run = 0;
  int          n_wclr = 0;
  int          n;
  int          n_oe = 0;

  // resolved pins: device wins where it enables its driver
  assign pins = (io_oe_o & io_o) | (~io_oe_o & host_io);

  fpc_flash_ctrl uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk),
    .cs_n_i(cs_n), .io_i(pins), .io_o(io_o), .io_oe_o(io_oe_o), .qpi_mode_i(qpi_mode_i),
    .wip_i(wip_i), .wel_i(wel_i), .prot_err_i(prot_err_i), .prog_err_i(prog_err_i),
    .erase_err_i(erase_err_i), .dedicated_rst_i(dedicated_rst_i), .rd_addr_i(rd_addr_i),
    .rd_addr_next_o(rd_addr_next_o), .deep_sleep_o(deep_sleep_o), .ready_o(ready_o),
    .read_params_o(read_params_o), .dummy_cycles_o(dummy_cycles_o),
    .drive_strength_o(drive_strength_o), .ext_params_o(ext_params_o),
    .rst_pin_is_reset_o(rst_pin_is_reset_o), .wel_clr_o(wel_clr_o));

  fpc_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .io_o(host_io), .pin_i(pins));

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // watch the latch-clear pulses and any driving of the pins
  always @(negedge core_clk_i) if (wel_clr_o === 1'b1) n_wclr++;
  always @(io_oe_o) if (io_oe_o !== 4'h0) n_oe++;

  task automatic wrap_up;
    if (n_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // a frame, then the gap the core needs to act on it
  task automatic cmd(input logic [7:0] op, input logic [7:0] dat, input int nwr,
                     input int nrd);
    host.frame(qpi_mode_i, op, qpi_mode_i ? 2 : 8, dat, nwr, nrd, rd);
    repeat (8) @(negedge core_clk_i);
  endtask

  // bounded wait for sleep (sel 0) or ready (sel 1)
  task automatic wait_hi(input int sel, input int lim);
    n = 0;
    while (((sel == 0) ? deep_sleep_o : ready_o) !== 1'b1 && n < lim) begin
      @(negedge core_clk_i);
      n++;
    end
  endtask

  initial begin
    #200000;
    n_errors++;
    wrap_up;
  end

  initial begin
    {rst_n_i, qpi_mode_i, wip_i, wel_i, dedicated_rst_i} = 5'h00;
    {prot_err_i, prog_err_i, erase_err_i} = 3'h0;
    rd_addr_i = 24'h1234FF;
    repeat (5) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    `TB_CHK("params", 8'h00, read_params_o)
    `TB_CHK("drive", `FPC_ODS_RESET, drive_strength_o)
    `TB_CHK("ext", 8'hA0, ext_params_o)
    // latch-free write lands; latch-gated ones are refused without the latch
    cmd(`FPC_OP_RP_V, 8'hAE, 8, 0);
    `TB_CHK("params", 8'hAE, read_params_o)
    `TB_CHK("dummy", 4'h5, dummy_cycles_o)
    `TB_CHK("rstsel", 1'b1, rst_pin_is_reset_o)
    cmd(`FPC_OP_RP_V_WEL, 8'h11, 8, 0);
    cmd(`FPC_OP_RP_NV, 8'h22, 8, 0);
    cmd(`FPC_OP_EX_NV, 8'h40, 8, 0);
    `TB_CHK("params", 8'hAE, read_params_o)
    `TB_CHK("drive", 3'h5, drive_strength_o)
    `TB_CHK("wclr", 0, n_wclr)
    // a trailing partial byte cancels the write
    cmd(`FPC_OP_RP_V, 8'h33, 12, 0);
    `TB_CHK("params", 8'hAE, read_params_o)
    wel_i = 1'b1;
    cmd(`FPC_OP_RP_V_WEL, 8'h3C, 8, 0);
    `TB_CHK("params", 8'h3C, read_params_o)
    cmd(`FPC_OP_RP_NV, 8'h4D, 8, 0);
    `TB_CHK("params", 8'h4D, read_params_o)
    `TB_CHK("wclr", 2, n_wclr)
    wel_i = 1'b0;
    `TB_CHK("rstsel", 1'b0, rst_pin_is_reset_o)
    dedicated_rst_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    `TB_CHK("rstsel", 1'b1, rst_pin_is_reset_o)
    cmd(`FPC_OP_RD_RP, 8'h00, 0, 16);
    `TB_CHK("read_read_params_cmd", 16'h4D4D, rd)
    // every burst code against a page-local boundary end
    for (int c = 0; c < 8; c++) begin
      cmd(`FPC_OP_RP_V, 8'(c), 8, 0);
      exp_a = (c < 4) ? 24'h123500 : 24'h1234FF & ~((24'h000008 << (c - 4)) - 24'h000001);
      `TB_CHK("next", exp_a, rd_addr_next_o)
    end
    rd_addr_i = 24'h1234FE;
    repeat (2) @(negedge core_clk_i);
    `TB_CHK("next", 24'h1234FF, rd_addr_next_o)
    // four-line mode: nibble reads, sticky errors, extended writes
    qpi_mode_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    cmd(`FPC_OP_RD_RP, 8'h00, 0, 4);
    `TB_CHK("read_read_params_cmd", 16'h0707, rd)
    {prot_err_i, prog_err_i, erase_err_i} = 3'h7;
    @(negedge core_clk_i);
    {prot_err_i, prog_err_i, erase_err_i} = 3'h0;
    wip_i = 1'b1;
    cmd(`FPC_OP_RD_EX, 8'h00, 0, 4);
    `TB_CHK("rdex", 16'hAFAF, rd)
    wip_i = 1'b0;
    cmd(`FPC_OP_EX_V, 8'h20, 2, 0);
    `TB_CHK("ext", 8'h2E, ext_params_o)
    cmd(`FPC_OP_CLR_ERR, 8'h00, 0, 0);
    `TB_CHK("ext", 8'h20, ext_params_o)
    wel_i = 1'b1;
    cmd(`FPC_OP_EX_NV, 8'h60, 2, 0);
    wel_i = 1'b0;
    `TB_CHK("drive", 3'h3, drive_strength_o)
    // sleep opcode cut short, then whole
    host.frame(1'b1, `FPC_OP_SLEEP, 1, 8'h00, 0, 0, rd);
    repeat (320) @(negedge core_clk_i);
    `TB_CHK("sleep", 1'b0, deep_sleep_o)
    host.frame(1'b1, `FPC_OP_SLEEP, 2, 8'h00, 0, 0, rd);
    wait_hi(0, 300);
    `TB_CHK("sleep", 1'b1, deep_sleep_o)
    `TB_CHK("params", 8'h4D, read_params_o)
    // asleep: writes and reads are ignored
    n = n_oe;
    cmd(`FPC_OP_RP_V, 8'h55, 2, 0);
    cmd(`FPC_OP_RD_RP, 8'h00, 0, 4);
    `TB_CHK("params", 8'h4D, read_params_o)
    `TB_CHK("oe", n, n_oe)
    wip_i = 1'b1;
    cmd(`FPC_OP_WAKE, 8'h00, 0, 0);
    repeat (20) @(negedge core_clk_i);
    `TB_CHK("sleep", 1'b1, deep_sleep_o)
    wip_i = 1'b0;
    // release: nothing ready before recovery ends, ready by its end
    cmd(`FPC_OP_WAKE, 8'h00, 0, 0);
    repeat (100) @(negedge core_clk_i);
    `TB_CHK("ready", 1'b0, ready_o)
    wait_hi(1, 400);
    `TB_CHK("ready", 1'b1, ready_o)
    // single-line sleep and release as well
    qpi_mode_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    host.frame(1'b0, `FPC_OP_SLEEP, 8, 8'h00, 0, 0, rd);
    wait_hi(0, 300);
    `TB_CHK("sleep", 1'b1, deep_sleep_o)
    cmd(`FPC_OP_WAKE, 8'h00, 0, 0);
    wait_hi(1, 520);
    `TB_CHK("ready", 1'b1, ready_o)
    wrap_up;
  end
endmodule
